/* File: design/aso_pkg.sv */
package aso_pkg;

  // Stream geometry
  localparam int ASO_CHANNELS        = 8;
  localparam int ASO_WORD_BITS       = 12;
  localparam int ASO_BITCLK_RATIO    = 6;
  localparam int ASO_BITS_PER_BITCLK = ASO_WORD_BITS / ASO_BITCLK_RATIO;
  localparam int ASO_FRAME_HI_BITS   = ASO_WORD_BITS / 2;
  localparam int ASO_CNT_BITS        = 4;

  // Bus geometry; register offsets are word indices
  localparam int ASO_ADDR_W        = 12;
  localparam int ASO_DATA_W        = 32;
  localparam int ASO_BYTES_PER_REG = 4;
  localparam int ASO_IDX_CLAMP     = 70;
  localparam int ASO_IDX_POWER     = 71;
  localparam int ASO_IDX_STATUS    = 72;

  // Fields
  localparam int ASO_CLAMP_DIS_BIT   = 14;
  localparam int ASO_PWR_STANDBY_BIT = 0;
  localparam int ASO_PWR_FULL_BIT    = 1;
  localparam int ASO_PWR_LANE_BIT    = 2;
  localparam int ASO_PWR_CHAN_LSB    = 8;
  localparam int ASO_ST_SE_BIT       = 0;
  localparam int ASO_ST_BUF_BIT      = 1;
  localparam int ASO_ST_CLAMP_BIT    = 2;
  localparam int ASO_ST_STATE_LSB    = 3;
  localparam int ASO_ST_ALIVE_BIT    = 5;
  localparam int ASO_ST_GOOD_BIT     = 6;

  // Reset values
  localparam logic       ASO_CLAMP_DIS_RST = 1'b0;
  localparam logic       ASO_PWR_BIT_RST   = 1'b0;
  localparam logic [7:0] ASO_CHAN_PD_RST   = 8'h00;

  // Timing
  localparam int ASO_CLK_NS       = 20;
  localparam int ASO_AUTODET_NS   = 1000;
  localparam int ASO_STBY_WAKE_NS = 1000;
  localparam int ASO_FULL_WAKE_NS = 10000;
  localparam int ASO_ALIVE_NS     = 2000;
  localparam int ASO_TMR_W        = 16;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + ASO_CLK_NS - 1) / ASO_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ASO_AUTODET_CYC   = ns_to_cycles(ASO_AUTODET_NS);
  localparam int ASO_STBY_WAKE_CYC = ns_to_cycles(ASO_STBY_WAKE_NS);
  localparam int ASO_FULL_WAKE_CYC = ns_to_cycles(ASO_FULL_WAKE_NS);
  localparam int ASO_ALIVE_CYC     = ns_to_cycles(ASO_ALIVE_NS);

  typedef enum logic [1:0] {
    ASO_PWR_ACTIVE    = 2'b00,
    ASO_PWR_STANDBY   = 2'b01,
    ASO_PWR_FULL_DOWN = 2'b10,
    ASO_PWR_WAKING    = 2'b11
  } aso_pwr_e;

endpackage

/* File: design/aso_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface aso_link_if;
  logic                          rst;
  logic                          lane_en;
  logic [aso_pkg::ASO_CHANNELS-1:0] chan_en;
  logic                          word_toggle;
  modport ctl  (output rst, output lane_en, output chan_en,
                input word_toggle);
  modport link (input rst, input lane_en, input chan_en,
                output word_toggle);
endinterface
`default_nettype wire

/* File: design/aso_link_tx.sv */
`timescale 1ns/1ns
`default_nettype none
module aso_link_tx
  import aso_pkg::*;
#(
  parameter int CH = aso_pkg::ASO_CHANNELS,
  parameter int W  = aso_pkg::ASO_WORD_BITS
) (
  // Control side
  aso_link_if.link         lnk,
  // Link clock
  input  wire logic        i_lane_clk,
  // Conversion results, lane_clk domain
  input  wire logic [CH*W-1:0] i_conv_data,
  // Serial outputs
  output logic             o_sample_strobe,
  output logic [CH-1:0]    o_lane_data,
  output logic             o_lane_oe,
  output logic             o_frame,
  output logic             o_bit_clk
);
  localparam logic [ASO_CNT_BITS-1:0] LAST = ASO_CNT_BITS'(W - 1);

  logic                    rst_meta, rst_s, lane_meta, lane_s;
  logic [CH-1:0]           chan_meta, chan_s;
  logic [ASO_CNT_BITS-1:0] bit_cnt, next_cnt;
  logic [W-1:0]            shreg [CH];
  logic                    toggle, run;

  // Config is quasi-static; each bit is synchronised on its own
  always_ff @(posedge i_lane_clk) begin
    rst_meta  <= lnk.rst;
    rst_s     <= rst_meta;
    lane_meta <= lnk.lane_en;
    lane_s    <= lane_meta;
    chan_meta <= lnk.chan_en;
    chan_s    <= chan_meta;
  end

  always_comb begin
    next_cnt = (bit_cnt == LAST) ? '0 : bit_cnt + 1'b1;
    run = (bit_cnt == LAST) ? lane_s : o_lane_oe;
  end

  // One counter times every lane, so all converters sample together
  always_ff @(posedge i_lane_clk) begin
    if (rst_s) begin
      bit_cnt <= LAST;
    end else begin
      bit_cnt <= next_cnt;
    end
  end

  always_ff @(posedge i_lane_clk) begin
    o_sample_strobe <= ~rst_s & (next_cnt == LAST);
  end

  // MSB first; the word loads on the same edge that the frame rises
  always_ff @(posedge i_lane_clk) begin
    for (int c = 0; c < CH; c++) begin
      if (rst_s || !run || !chan_s[c]) begin
        shreg[c] <= '0;
      end else if (bit_cnt == LAST) begin
        shreg[c] <= i_conv_data[c*W +: W];
      end else begin
        shreg[c] <= {shreg[c][W-2:0], 1'b0};
      end
    end
  end

  always_comb begin
    for (int c = 0; c < CH; c++) begin
      o_lane_data[c] = shreg[c][W-1];
    end
  end

  always_ff @(posedge i_lane_clk) begin
    if (rst_s || !run) begin
      o_frame   <= 1'b0;
      o_bit_clk <= 1'b0;
    end else begin
      o_frame   <= int'(next_cnt) < ASO_FRAME_HI_BITS;
      o_bit_clk <= (int'(next_cnt) % ASO_BITS_PER_BITCLK) == 0;
    end
  end

  always_ff @(posedge i_lane_clk) begin
    o_lane_oe <= run & ~rst_s;
  end

  // Word events leave this domain as a toggle
  always_ff @(posedge i_lane_clk) begin
    if (rst_s) begin
      toggle <= 1'b0;
    end else if (bit_cnt == LAST) begin
      toggle <= ~toggle;
    end
  end
  assign lnk.word_toggle = toggle;

endmodule
`default_nettype wire

/* File: design/aso_top.sv */
// Contract
// - Each of eight converters is shifted out on its own lane at twelve bits per sample.
// - A frame marker toggles once per sample period and its edges bound each word; the code raises it at each word start and drops it after six bits.
// - A bit clock at six times the sample rate has one edge at each serial bit.
// - The clamp is on after reset and a one in bit 14 of register index 70 turns it off.
// - Standby turns off everything but the reference so that wake-up is quick.
// - Full power-down turns off everything but the digital logic and wakes more slowly.
// - An eight-bit field powers down the channel pair of each converter separately.
// - A separate control powers down the serial output lanes alone.
// - All channels sample from one shared sampling tick with equal delay.
// - A negative clock input held at ground disables the clock buffer for single-ended use.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module aso_top
  import aso_pkg::*;
#(
  parameter int CH            = aso_pkg::ASO_CHANNELS,
  parameter int W             = aso_pkg::ASO_WORD_BITS,
  parameter int AUTODET_CYC   = aso_pkg::ASO_AUTODET_CYC,
  parameter int STBY_WAKE_CYC = aso_pkg::ASO_STBY_WAKE_CYC,
  parameter int FULL_WAKE_CYC = aso_pkg::ASO_FULL_WAKE_CYC,
  parameter int ALIVE_CYC     = aso_pkg::ASO_ALIVE_CYC
) (
  // System
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  // APB slave
  input  wire logic                            i_psel,
  input  wire logic                            i_penable,
  input  wire logic                            i_pwrite,
  input  wire logic [aso_pkg::ASO_ADDR_W-1:0]  i_paddr,
  input  wire logic [aso_pkg::ASO_DATA_W-1:0]  i_pwdata,
  input  wire logic [3:0]                      i_pstrb,
  output logic                                 o_pready,
  output logic [aso_pkg::ASO_DATA_W-1:0]       o_prdata,
  output logic                                 o_pslverr,
  // Clock input sense
  input  wire logic                            i_clock_in_neg,
  // Analog power and clamp controls
  output logic                                 o_ref_en,
  output logic [CH-1:0]                        o_chan_pwr,
  output logic                                 o_clk_buf_en,
  output logic                                 o_clamp_en,
  output logic                                 o_power_good,
  // Serial link
  input  wire logic                            i_lane_clk,
  input  wire logic [CH*W-1:0]                 i_conv_data,
  output logic                                 o_sample_strobe,
  output logic [CH-1:0]                        o_lane_data,
  output logic                                 o_lane_oe,
  output logic                                 o_frame,
  output logic                                 o_bit_clk
);

  typedef logic [ASO_TMR_W-1:0] aso_tmr_t;

  localparam aso_tmr_t AUTODET_T = ASO_TMR_W'(AUTODET_CYC);
  localparam aso_tmr_t STBY_T    = ASO_TMR_W'(STBY_WAKE_CYC);
  localparam aso_tmr_t FULL_T    = ASO_TMR_W'(FULL_WAKE_CYC);
  localparam aso_tmr_t ALIVE_T   = ASO_TMR_W'(ALIVE_CYC);

  function automatic logic addr_hit(input logic [ASO_ADDR_W-1:0] a,
                                    input int idx);
    return a == ASO_ADDR_W'(idx * ASO_BYTES_PER_REG);
  endfunction

  aso_link_if lnk ();

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic          clamp_dis;
  logic          standby_req;
  logic          full_req;
  logic          lane_pd;
  logic [CH-1:0] chan_pd;

  // ------------------------------------------------------------------
  // APB: zero wait states, read data captured in the setup phase
  // ------------------------------------------------------------------
  logic setup;
  logic access;
  logic mapped;
  logic wr_clamp;
  logic wr_power;

  assign setup  = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign mapped = addr_hit(i_paddr, ASO_IDX_CLAMP) |
                  addr_hit(i_paddr, ASO_IDX_POWER) |
                  addr_hit(i_paddr, ASO_IDX_STATUS);

  assign o_pready  = access;
  assign o_pslverr = access & ~mapped;

  assign wr_clamp = access & i_pwrite & addr_hit(i_paddr, ASO_IDX_CLAMP);
  assign wr_power = access & i_pwrite & addr_hit(i_paddr, ASO_IDX_POWER);

  // Only the byte lane holding bit 14 matters here
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clamp_dis <= ASO_CLAMP_DIS_RST;
    end else if (wr_clamp && i_pstrb[ASO_CLAMP_DIS_BIT / 8]) begin
      clamp_dis <= i_pwdata[ASO_CLAMP_DIS_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      standby_req <= ASO_PWR_BIT_RST;
      full_req    <= ASO_PWR_BIT_RST;
      lane_pd     <= ASO_PWR_BIT_RST;
    end else if (wr_power && i_pstrb[0]) begin
      standby_req <= i_pwdata[ASO_PWR_STANDBY_BIT];
      full_req    <= i_pwdata[ASO_PWR_FULL_BIT];
      lane_pd     <= i_pwdata[ASO_PWR_LANE_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan_pd <= ASO_CHAN_PD_RST;
    end else if (wr_power && i_pstrb[ASO_PWR_CHAN_LSB / 8]) begin
      chan_pd <= i_pwdata[ASO_PWR_CHAN_LSB +: CH];
    end
  end

  // ------------------------------------------------------------------
  // Clock-input autodetect
  // ------------------------------------------------------------------
  logic     neg_meta;
  logic     neg_sync;
  logic     neg_prev;
  aso_tmr_t quiet_cnt;
  logic     single_ended;

  always_ff @(posedge i_clk) begin
    neg_meta <= i_clock_in_neg;
    neg_sync <= neg_meta;
    neg_prev <= neg_sync;
  end

  // A toggling or high input means a differential source; only a
  // steady low over the whole window counts as tied to ground.
  // A differential clock can alias onto i_clk, which only delays the
  // verdict because any seen edge restarts the window.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      quiet_cnt <= '0;
    end else if (neg_sync != neg_prev) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt != AUTODET_T) begin
      quiet_cnt <= quiet_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      single_ended <= 1'b0;
    end else if (neg_sync != neg_prev) begin
      single_ended <= 1'b0;
    end else if (quiet_cnt == AUTODET_T) begin
      single_ended <= ~neg_sync;
    end
  end

  // ------------------------------------------------------------------
  // Power state machine; full power-down outranks standby
  // ------------------------------------------------------------------
  aso_pwr_e pwr_state;
  aso_pwr_e next_pwr_state;
  aso_tmr_t wake_cnt;
  aso_tmr_t next_wake_cnt;

  always_comb begin
    next_pwr_state = pwr_state;
    next_wake_cnt  = wake_cnt;
    unique case (pwr_state)
      ASO_PWR_ACTIVE: begin
        if (full_req) begin
          next_pwr_state = ASO_PWR_FULL_DOWN;
        end else if (standby_req) begin
          next_pwr_state = ASO_PWR_STANDBY;
        end
      end
      ASO_PWR_STANDBY: begin
        if (full_req) begin
          next_pwr_state = ASO_PWR_FULL_DOWN;
        end else if (!standby_req) begin
          next_pwr_state = ASO_PWR_WAKING;
          next_wake_cnt  = STBY_T;
        end
      end
      ASO_PWR_FULL_DOWN: begin
        if (!full_req) begin
          next_pwr_state = ASO_PWR_WAKING;
          next_wake_cnt  = FULL_T;
        end
      end
      ASO_PWR_WAKING: begin
        if (full_req) begin
          next_pwr_state = ASO_PWR_FULL_DOWN;
        end else if (standby_req) begin
          next_pwr_state = ASO_PWR_STANDBY;
        end else if (wake_cnt <= aso_tmr_t'(1)) begin
          next_pwr_state = ASO_PWR_ACTIVE;
          next_wake_cnt  = '0;
        end else begin
          next_wake_cnt  = wake_cnt - 1'b1;
        end
      end
    endcase
  end

  // Leaving reset counts as a cold wake, so outputs settle first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwr_state <= ASO_PWR_FULL_DOWN;
      wake_cnt  <= '0;
    end else begin
      pwr_state <= next_pwr_state;
      wake_cnt  <= next_wake_cnt;
    end
  end

  // ------------------------------------------------------------------
  // Registered power controls
  // ------------------------------------------------------------------
  logic analog_on;
  logic lanes_on;

  assign analog_on = (pwr_state == ASO_PWR_ACTIVE) ||
                     (pwr_state == ASO_PWR_WAKING);
  assign lanes_on  = (pwr_state == ASO_PWR_ACTIVE) && !lane_pd;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ref_en     <= 1'b0;
      o_chan_pwr   <= '0;
      o_clk_buf_en <= 1'b0;
      o_clamp_en   <= 1'b0;
      o_power_good <= 1'b0;
    end else begin
      o_ref_en     <= pwr_state != ASO_PWR_FULL_DOWN;
      o_chan_pwr   <= analog_on ? ~chan_pd : '0;
      o_clk_buf_en <= analog_on & ~single_ended;
      o_clamp_en   <= analog_on & ~clamp_dis;
      o_power_good <= pwr_state == ASO_PWR_ACTIVE;
    end
  end

  // Lanes stay quiet until the analog side has fully woken
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lnk.rst     <= 1'b1;
      lnk.lane_en <= 1'b0;
      lnk.chan_en <= '0;
    end else begin
      lnk.rst     <= 1'b0;
      lnk.lane_en <= lanes_on;
      lnk.chan_en <= lanes_on ? ~chan_pd : '0;
    end
  end

  // ------------------------------------------------------------------
  // Link activity seen from the bus side
  // ------------------------------------------------------------------
  logic     tog_meta;
  logic     tog_sync;
  logic     tog_prev;
  aso_tmr_t alive_cnt;
  logic     link_alive;

  always_ff @(posedge i_clk) begin
    tog_meta <= lnk.word_toggle;
    tog_sync <= tog_meta;
    tog_prev <= tog_sync;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alive_cnt <= '0;
    end else if (tog_sync != tog_prev) begin
      alive_cnt <= ALIVE_T;
    end else if (alive_cnt != '0) begin
      alive_cnt <= alive_cnt - 1'b1;
    end
  end

  assign link_alive = alive_cnt != '0;

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [ASO_DATA_W-1:0] rd_value;

  always_comb begin
    rd_value = '0;
    if (addr_hit(i_paddr, ASO_IDX_CLAMP)) begin
      rd_value[ASO_CLAMP_DIS_BIT] = clamp_dis;
    end else if (addr_hit(i_paddr, ASO_IDX_POWER)) begin
      rd_value[ASO_PWR_STANDBY_BIT]     = standby_req;
      rd_value[ASO_PWR_FULL_BIT]        = full_req;
      rd_value[ASO_PWR_LANE_BIT]        = lane_pd;
      rd_value[ASO_PWR_CHAN_LSB +: CH]  = chan_pd;
    end else if (addr_hit(i_paddr, ASO_IDX_STATUS)) begin
      rd_value[ASO_ST_SE_BIT]           = single_ended;
      rd_value[ASO_ST_BUF_BIT]          = o_clk_buf_en;
      rd_value[ASO_ST_CLAMP_BIT]        = o_clamp_en;
      rd_value[ASO_ST_STATE_LSB +: 2]   = pwr_state;
      rd_value[ASO_ST_ALIVE_BIT]        = link_alive;
      rd_value[ASO_ST_GOOD_BIT]         = o_power_good;
    end
  end

  // Captured at setup so the access cycle can answer at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= '0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? '0 : rd_value;
    end
  end

  // ------------------------------------------------------------------
  // Serial link on its own clock
  // ------------------------------------------------------------------
  aso_link_tx #(
    .CH (CH),
    .W  (W)
  ) u_link (
    .lnk             (lnk.link),
    .i_lane_clk      (i_lane_clk),
    .i_conv_data     (i_conv_data),
    .o_sample_strobe (o_sample_strobe),
    .o_lane_data     (o_lane_data),
    .o_lane_oe       (o_lane_oe),
    .o_frame         (o_frame),
    .o_bit_clk       (o_bit_clk)
  );

endmodule
`default_nettype wire

/* File: verif/aso_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module aso_top_sva
  import aso_pkg::*;
#(
  parameter int AUTODET_CYC = 8
) (
  // System and bus
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  // Power and clock sense
  input wire logic        i_clock_in_neg,
  input wire logic        o_ref_en,
  input wire logic [7:0]  o_chan_pwr,
  input wire logic        o_clk_buf_en,
  input wire logic        o_clamp_en,
  input wire logic        o_power_good,
  // Link
  input wire logic        i_lane_clk,
  input wire logic [95:0] i_conv_data,
  input wire logic        o_sample_strobe,
  input wire logic [7:0]  o_lane_data,
  input wire logic        o_lane_oe,
  input wire logic        o_frame,
  input wire logic        o_bit_clk
);
  localparam logic [11:0] A_CLAMP = 12'(ASO_IDX_CLAMP * ASO_BYTES_PER_REG);
  localparam logic [11:0] A_POWER = 12'(ASO_IDX_POWER * ASO_BYTES_PER_REG);
  logic        wr_clamp;
  logic        wr_pwr;
  logic        clamp_dis_q;
  logic [7:0]  chan_pd_q;
  logic [7:0]  msb_w;
  logic [15:0] low_cnt;
  // Only writes made while active are tracked; other states mask outputs
  assign wr_clamp = i_psel && i_penable && i_pwrite && i_paddr == A_CLAMP
                    && i_pstrb[1] && o_power_good;
  assign wr_pwr = i_psel && i_penable && i_pwrite && i_paddr == A_POWER
                  && i_pstrb == 4'hF && o_power_good;
  always_ff @(posedge i_clk) begin
    if (i_rst) clamp_dis_q <= 1'b0;
    else if (wr_clamp) clamp_dis_q <= i_pwdata[14];
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) chan_pd_q <= 8'h00;
    else if (wr_pwr) chan_pd_q <= i_pwdata[15:8];
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clock_in_neg) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
  end
  always_comb begin
    for (int c = 0; c < 8; c++) msb_w[c] = i_conv_data[c * 12 + 11];
  end
  chk_strobe_period: assert property (@(posedge i_lane_clk) disable iff (i_rst)
    o_sample_strobe |=> !o_sample_strobe [*8] ##1 !o_sample_strobe [*3]
    ##1 o_sample_strobe) else $error("strobe spacing wrong");
  chk_frame_width: assert property (@(posedge i_lane_clk)
    disable iff (i_rst || !o_lane_oe)
    $rose(o_frame) |-> o_frame [*6] ##1 !o_frame [*6])
    else $error("frame width wrong");
  chk_bitclk_toggle: assert property (@(posedge i_lane_clk) disable iff (i_rst)
    o_lane_oe && $past(o_lane_oe) |-> o_bit_clk != $past(o_bit_clk))
    else $error("bit clock did not toggle");
  chk_clamp_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_clamp |-> ##[1:3] (o_clamp_en == !clamp_dis_q))
    else $error("clamp not following write");
  chk_standby_ref: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_pwr && i_pwdata[1:0] == 2'b01
    |-> ##[1:3] (o_ref_en && o_chan_pwr == 8'h00 && !o_power_good))
    else $error("standby state wrong");
  chk_ref_off_all: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_ref_en |-> o_chan_pwr == 8'h00 && !o_power_good)
    else $error("channels on without reference");
  chk_chan_pair: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_pwr && i_pwdata[2:0] == 3'b000 |-> ##[1:3] (o_chan_pwr == ~chan_pd_q))
    else $error("channel pair power wrong");
  chk_lane_quiet: assert property (@(posedge i_lane_clk) disable iff (i_rst)
    !o_lane_oe |-> o_lane_data == 8'h00 && !o_frame && !o_bit_clk)
    else $error("lanes active while off");
  chk_neg_edge: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(i_clock_in_neg) && o_power_good |-> ##[1:4] o_clk_buf_en)
    else $error("buffer not back on");
  chk_se_detect: assert property (@(posedge i_clk) disable iff (i_rst)
    low_cnt >= 16'(AUTODET_CYC + 5) |-> !o_clk_buf_en)
    else $error("buffer on with grounded input");
  chk_msb_first: assert property (@(posedge i_lane_clk) disable iff (i_rst)
    o_sample_strobe && o_lane_oe && o_chan_pwr == 8'hFF
    |=> (o_lane_data == $past(msb_w) || !o_lane_oe))
    else $error("first bit is not the msb");
endmodule
bind aso_top aso_top_sva #(.AUTODET_CYC(AUTODET_CYC)) sva_u (.i_clk, .i_rst,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
  .i_clock_in_neg, .o_ref_en, .o_chan_pwr, .o_clk_buf_en, .o_clamp_en,
  .o_power_good, .i_lane_clk, .i_conv_data, .o_sample_strobe, .o_lane_data,
  .o_lane_oe, .o_frame, .o_bit_clk);
`default_nettype wire

/* File: verif/aso_cap_model.sv */
`timescale 1ns/1ns
`default_nettype none
module aso_cap_model (
  // Control
  input  wire logic        i_rst,
  input  wire logic        i_lane_clk,
  // Lanes
  input  wire logic        i_frame,
  input  wire logic [7:0]  i_lane_data,
  // Captured words
  output logic      [95:0] o_words,
  output int               o_count
);
  logic        frame_q;
  logic [3:0]  bitn;
  logic [11:0] sh [8];
  // Word alignment comes only from the frame edge, as real capture logic does
  always_ff @(posedge i_lane_clk) begin
    if (i_rst) begin
      frame_q <= 1'b0;
      bitn    <= 4'h0;
      o_count <= 0;
      o_words <= '0;
    end else begin
      frame_q <= i_frame;
      if (i_frame && !frame_q) bitn <= 4'h1;
      else if (bitn != 4'h0) bitn <= (bitn == 4'hB) ? 4'h0 : bitn + 4'h1;
      for (int c = 0; c < 8; c++) sh[c] <= {sh[c][10:0], i_lane_data[c]};
      if (bitn == 4'hB) begin
        for (int c = 0; c < 8; c++)
          o_words[c * 12 +: 12] <= {sh[c][10:0], i_lane_data[c]};
        o_count <= o_count + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/adc_serial_output_and_power_ctrl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_serial_output_and_power_ctrl_tb_top;
  import aso_pkg::*;
  localparam int AD = 8;
  localparam int SW = 4;
  localparam logic [11:0] A_CLAMP = 12'(ASO_IDX_CLAMP * ASO_BYTES_PER_REG);
  localparam logic [11:0] A_POWER = 12'(ASO_IDX_POWER * ASO_BYTES_PER_REG);
  localparam logic [11:0] A_STAT  = 12'(ASO_IDX_STATUS * ASO_BYTES_PER_REG);
  logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, i_clock_in_neg;
  logic        i_lane_clk, o_pready, o_pslverr, o_ref_en, o_clk_buf_en;
  logic        o_clamp_en, o_power_good, o_sample_strobe, o_lane_oe;
  logic        o_frame, o_bit_clk, e;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, r;
  logic [3:0]  i_pstrb;
  logic [7:0]  o_chan_pwr, o_lane_data;
  logic [95:0] i_conv_data, cap_words;
  int          cap_count, miscompares, cmp_count, ns, nf;
  int          cyc = 0;
  aso_top #(.AUTODET_CYC(AD), .STBY_WAKE_CYC(SW), .FULL_WAKE_CYC(10),
    .ALIVE_CYC(20)) dut_u (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr,
    .i_clock_in_neg, .o_ref_en, .o_chan_pwr, .o_clk_buf_en, .o_clamp_en,
    .o_power_good, .i_lane_clk, .i_conv_data, .o_sample_strobe,
    .o_lane_data, .o_lane_oe, .o_frame, .o_bit_clk);
  aso_cap_model cap_u (.i_rst, .i_lane_clk, .i_frame(o_frame),
    .i_lane_data(o_lane_data), .o_words(cap_words), .o_count(cap_count));
  always #10 i_clk = ~i_clk;
  // The 1 ns offset still lines a link rising edge up with a system rising edge every 60 ns
  initial begin
    i_lane_clk = 1'b0;
    #1;
    forever #3 i_lane_clk = ~i_lane_clk;
  end
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      miscompares++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= 4'hF;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk);
    while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input int lag);
    apb(1'b1, a, d, r, e);
    repeat (lag) @(posedge i_clk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r & m);
  endtask
  task automatic wait_good(output int n);
    n = 0;
    while (o_power_good !== 1'b1 && n < 2000) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  task automatic stream(input logic [11:0] b, input logic [7:0] on);
    int s;
    @(posedge i_lane_clk);
    for (int c = 0; c < 8; c++) i_conv_data[c * 12 +: 12] <= b ^ 12'(c * 273);
    s = cap_count;
    for (int k = 0; k < 400 && cap_count < s + 3; k++) @(posedge i_lane_clk);
    for (int c = 0; c < 8; c++)
      chk("lane word", on[c] ? 32'(b ^ 12'(c * 273)) : 32'h0,
          32'(cap_words[c * 12 +: 12]));
  endtask
  initial begin
    {i_clk, i_psel, i_penable, i_pwrite} = 4'h0;
    {i_paddr, i_pwdata, i_pstrb, i_conv_data} = '0;
    {i_rst, i_clock_in_neg} = 2'b11;
    {miscompares, cmp_count} = 0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rd("clamp reset", A_CLAMP, 32'hFFFFFFFF, 32'h0);
    rd("power reset", A_POWER, 32'hFFFFFFFF, 32'h0);
    wait_good(ns);
    chk("clamp on", 32'h1, 32'(o_clamp_en));
    chk("buffer on", 32'h1, 32'(o_clk_buf_en));
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    wr(A_CLAMP, 32'h00004000, 3);
    chk("clamp off", 32'h0, 32'(o_clamp_en));
    rd("clamp readback", A_CLAMP, 32'hFFFFFFFF, 32'h00004000);
    wr(A_CLAMP, 32'h0, 3);
    chk("clamp back", 32'h1, 32'(o_clamp_en));
    stream(12'hA5C, 8'hFF);
    rd("link alive", A_STAT, 32'h20, 32'h20);
    wr(A_POWER, 32'h00000500, 3);
    chk("pair power", 32'hFA, 32'(o_chan_pwr));
    stream(12'h3C6, 8'hFA);
    wr(A_POWER, 32'h4, 3);
    repeat (6) @(posedge i_lane_clk);
    chk("lanes off", 32'h0, 32'(o_lane_oe));
    chk("pairs kept", 32'hFF, 32'(o_chan_pwr));
    wr(A_POWER, 32'h0, 3);
    repeat (6) @(posedge i_lane_clk);
    chk("lanes on", 32'h1, 32'(o_lane_oe));
    wr(A_POWER, 32'h1, 3);
    chk("standby", 32'h1, {o_chan_pwr, o_ref_en});
    rd("standby state", A_STAT, 32'h58, 32'h08);
    wr(A_POWER, 32'h0, 0);
    wait_good(ns);
    wr(A_POWER, 32'h3, 3);
    chk("full down", 32'h0, {o_chan_pwr, o_ref_en});
    rd("full state", A_STAT, 32'h58, 32'h10);
    wr(A_POWER, 32'h0, 0);
    wait_good(nf);
    chk("standby wake", 32'h1, 32'(ns >= SW));
    chk("full wake slower", 32'h1, 32'(nf > ns));
    i_clock_in_neg <= 1'b0;
    repeat (AD + 6) @(posedge i_clk);
    chk("single ended", 32'h0, 32'(o_clk_buf_en));
    rd("se status", A_STAT, 32'h3, 32'h1);
    i_clock_in_neg <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk("differential", 32'h1, 32'(o_clk_buf_en));
    final_report;
  end
endmodule
`default_nettype wire
